/* rtl/tbu_cfg.svh */
`ifndef TBU_CFG_SVH
`define TBU_CFG_SVH

// register byte addresses
`define TBU_ADDR_CTRL    4'h0
`define TBU_ADDR_STATUS  4'h1
`define TBU_ADDR_CLEAR   4'h2
`define TBU_ADDR_IRQ_EN  4'h3

// control register fields
`define TBU_CTRL_FLAG    7
`define TBU_CTRL_RATE_HI 6
`define TBU_CTRL_RATE_LO 4
`define TBU_CTRL_ACK     3
`define TBU_CTRL_IE      2
`define TBU_CTRL_ON      1

// status, clear and irq enable fields
`define TBU_EV_TICK      0
`define TBU_EV_MISSED    1

// reset value of every control and status bit
`define TBU_RESET_BIT    1'b0

// divider chain and its taps, one per rate code
`define TBU_DIV_STAGES   18
`define TBU_TAP_R0       17
`define TBU_TAP_R1       16
`define TBU_TAP_R2       15
`define TBU_TAP_R3       14
`define TBU_TAP_R4       5
`define TBU_TAP_R5       4
`define TBU_TAP_R6       3
`define TBU_TAP_R7       2

// nominal reference rate in hertz
`define TBU_OSC_REF_HZ   32768

// oscillator source codes
`define TBU_OSC_INTERNAL 2'h0
`define TBU_OSC_RC       2'h1
`define TBU_OSC_CRYSTAL  2'h2

// pin sampling depth
`define TBU_SYNC_STAGES  3

`endif

/* rtl/tbu_div_if.sv */
`timescale 1ns/1ps
interface tbu_div_if;
	import tbu_pkg::*;

	logic      osc_tick;  // one pulse per rising reference edge
	logic      hold_zero; // divider forced to zero
	logic      freeze;    // divider stands still
	tbu_rate_t rate;      // chosen tap
	logic      rollover;  // one pulse per period

	modport sync_mp (output osc_tick);
	modport div_mp  (input osc_tick, hold_zero, freeze, rate, output rollover);
	modport core_mp (input rollover, output hold_zero, freeze, rate);
endinterface : tbu_div_if

/* rtl/tbu_divider.sv */
`timescale 1ns/1ps
`include "tbu_cfg.svh"
module tbu_divider #(
	parameter int unsigned STAGES = `TBU_DIV_STAGES
) (
	input  wire logic  clk_i,
	input  wire logic  reset_n_i,
	tbu_div_if.div_mp  div_if
);
	import tbu_pkg::*;

	logic [STAGES-1:0] count_q;
	logic              tap_prev_q;
	logic              tap_w;

	// rising edge of the tap: first after half a period, then every period
	assign tap_w = count_q[tbu_tap_index(div_if.rate)];
	assign div_if.rollover = tap_w & ~tap_prev_q;

	// counter held at zero while off, counts reference edges while on and not frozen
	always_ff @(posedge clk_i) begin
		if (!reset_n_i || div_if.hold_zero) begin
			count_q    <= '0;
			tap_prev_q <= `TBU_RESET_BIT;
		end else begin
			if (div_if.osc_tick && !div_if.freeze) begin
				count_q <= STAGES'(count_q + 1'b1);
			end
			tap_prev_q <= tap_w;
		end
	end
endmodule : tbu_divider

/* rtl/tbu_osc_sync.sv */
`timescale 1ns/1ps
`include "tbu_cfg.svh"
module tbu_osc_sync (
	input  wire logic   clk_i,
	input  wire logic   reset_n_i,
	input  wire logic   osc_ref_clock_i,
	tbu_div_if.sync_mp  div_if
);
	import tbu_pkg::*;

	logic [`TBU_SYNC_STAGES-1:0] sync_q;
	logic                        level_q;
	logic                        agree_w;

	// last two stages must agree before a level counts
	assign agree_w = sync_q[2] == sync_q[1];
	assign div_if.osc_tick = agree_w & sync_q[2] & ~level_q;

	// sampling chain and accepted level
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sync_q  <= '0;
			level_q <= `TBU_RESET_BIT;
		end else begin
			sync_q <= {sync_q[1:0], osc_ref_clock_i};
			if (agree_w) begin
				level_q <= sync_q[2];
			end
		end
	end
endmodule : tbu_osc_sync

/* rtl/tbu_periodic_tick_unit.sv */
`timescale 1ns/1ps
`include "tbu_cfg.svh"

module tbu_periodic_tick_unit (
	input  wire logic                clk_i,
	input  wire logic                reset_n_i,
	input  wire tbu_pkg::tbu_addr_t  addr_i,
	input  wire tbu_pkg::tbu_byte_t  wdata_i,
	input  wire logic                wr_i,
	input  wire logic                rd_i,
	output tbu_pkg::tbu_byte_t       rdata_o,
	input  wire logic                osc_ref_clock_i,
	input  wire tbu_pkg::tbu_osc_sel_t osc_sel_i,
	input  wire logic                stop_internal_osc_keep_i,
	input  wire logic                stop_rc_osc_keep_i,
	input  wire logic                stop_crystal_osc_keep_i,
	input  wire logic                wait_mode_i,
	input  wire logic                stop_mode_i,
	output logic                     irq_o
);
	import tbu_pkg::*;

	// control state
	logic      block_en_q;
	logic      block_en_d;
	logic      irq_en_q;
	logic      irq_en_d;
	logic      missed_en_q;
	logic      missed_en_d;
	tbu_rate_t rate_q;
	tbu_rate_t rate_d;

	// sticky event state
	logic      pending_q;
	logic      pending_d;
	logic      missed_q;
	logic      missed_d;

	// registered outputs
	tbu_byte_t rdata_q;
	tbu_byte_t rdata_d;
	logic      irq_q;
	logic      irq_d;

	// bus decode
	logic      bus_open_w;
	logic      wr_ok_w;
	logic      rd_ok_w;
	logic      wr_ctrl_w;
	logic      wr_clear_w;
	logic      wr_irq_en_w;
	logic      hit_ctrl_w;
	logic      hit_status_w;
	logic      hit_clear_w;
	logic      hit_irq_en_w;

	// event terms
	logic      rollover_w;
	logic      ack_tick_w;
	logic      ack_missed_w;
	logic      missed_ev_w;

	// low power terms
	logic      osc_kept_w;
	logic      freeze_w;

	// read images
	tbu_byte_t ctrl_img_w;
	tbu_byte_t status_img_w;
	tbu_byte_t irq_en_img_w;
	tbu_byte_t read_mux_w;

	// link between the core and its two helpers
	tbu_div_if div_if ();

	// reference pin sampling
	tbu_osc_sync u_sync (
		.clk_i           (clk_i),
		.reset_n_i       (reset_n_i),
		.osc_ref_clock_i (osc_ref_clock_i),
		.div_if          (div_if.sync_mp)
	);

	// divider chain and tap edge
	tbu_divider #(
		.STAGES (`TBU_DIV_STAGES)
	) u_div (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.div_if    (div_if.div_mp)
	);

	// whether the selected oscillator runs on through stop
	assign osc_kept_w =
		((osc_sel_i == `TBU_OSC_INTERNAL) & stop_internal_osc_keep_i) |
		((osc_sel_i == `TBU_OSC_RC)       & stop_rc_osc_keep_i) |
		((osc_sel_i == `TBU_OSC_CRYSTAL)  & stop_crystal_osc_keep_i);

	// divider stands still in stop unless its oscillator is kept
	assign freeze_w = stop_mode_i & ~osc_kept_w;

	// drive the divider from the control state and the low power terms
	assign div_if.hold_zero = ~block_en_q;
	assign div_if.freeze    = freeze_w;
	assign div_if.rate      = rate_q;
	assign rollover_w       = div_if.rollover;

	// register file shut off in wait and stop
	assign bus_open_w = ~wait_mode_i & ~stop_mode_i;
	assign wr_ok_w    = wr_i & bus_open_w;
	assign rd_ok_w    = rd_i & bus_open_w;

	// address decode
	assign hit_ctrl_w   = addr_i == `TBU_ADDR_CTRL;
	assign hit_status_w = addr_i == `TBU_ADDR_STATUS;
	assign hit_clear_w  = addr_i == `TBU_ADDR_CLEAR;
	assign hit_irq_en_w = addr_i == `TBU_ADDR_IRQ_EN;

	// write strobes per register
	assign wr_ctrl_w   = wr_ok_w & hit_ctrl_w;
	assign wr_clear_w  = wr_ok_w & hit_clear_w;
	assign wr_irq_en_w = wr_ok_w & hit_irq_en_w;

	// acknowledge: only a written 1 clears
	assign ack_tick_w =
		(wr_ctrl_w & wdata_i[`TBU_CTRL_ACK]) |
		(wr_clear_w & wdata_i[`TBU_EV_TICK]);
	assign ack_missed_w = wr_clear_w & wdata_i[`TBU_EV_MISSED];

	// a period ended while the previous one was still unacknowledged
	assign missed_ev_w = rollover_w & pending_q & ~ack_tick_w;

	// next control state
	always_comb begin
		block_en_d  = block_en_q;
		irq_en_d    = irq_en_q;
		missed_en_d = missed_en_q;
		rate_d      = rate_q;
		if (wr_ctrl_w) begin
			block_en_d = wdata_i[`TBU_CTRL_ON];
			irq_en_d   = wdata_i[`TBU_CTRL_IE];
			rate_d     = wdata_i[`TBU_CTRL_RATE_HI:`TBU_CTRL_RATE_LO];
		end
		if (wr_irq_en_w) begin
			irq_en_d    = wdata_i[`TBU_EV_TICK];
			missed_en_d = wdata_i[`TBU_EV_MISSED];
		end
	end

	// sticky flags: a rollover wins over a clear in the same cycle
	assign pending_d = rollover_w | (pending_q & ~ack_tick_w);
	assign missed_d  = missed_ev_w | (missed_q & ~ack_missed_w);

	// level request from the next flag and enable values
	assign irq_d =
		(pending_d & irq_en_d) | (missed_d & missed_en_d);

	// control register image; the acknowledge bit always reads zero
	always_comb begin
		ctrl_img_w = '0;
		ctrl_img_w[`TBU_CTRL_FLAG] = pending_q;
		ctrl_img_w[`TBU_CTRL_RATE_HI:`TBU_CTRL_RATE_LO] = rate_q;
		ctrl_img_w[`TBU_CTRL_ACK]  = `TBU_RESET_BIT;
		ctrl_img_w[`TBU_CTRL_IE]   = irq_en_q;
		ctrl_img_w[`TBU_CTRL_ON]   = block_en_q;
	end

	// status image of the sticky flags
	always_comb begin
		status_img_w = '0;
		status_img_w[`TBU_EV_TICK]   = pending_q;
		status_img_w[`TBU_EV_MISSED] = missed_q;
	end

	// enable image
	always_comb begin
		irq_en_img_w = '0;
		irq_en_img_w[`TBU_EV_TICK]   = irq_en_q;
		irq_en_img_w[`TBU_EV_MISSED] = missed_en_q;
	end

	// read select; clear register and unmapped addresses read zero
	assign read_mux_w =
		hit_ctrl_w   ? ctrl_img_w :
		hit_status_w ? status_img_w :
		hit_irq_en_w ? irq_en_img_w : '0;

	// read data stands for the one cycle after the strobe only
	assign rdata_d = rd_ok_w ? read_mux_w : '0;

	// control registers
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			block_en_q  <= `TBU_RESET_BIT;
			irq_en_q    <= `TBU_RESET_BIT;
			missed_en_q <= `TBU_RESET_BIT;
			rate_q      <= '0;
		end else begin
			block_en_q  <= block_en_d;
			irq_en_q    <= irq_en_d;
			missed_en_q <= missed_en_d;
			rate_q      <= rate_d;
		end
	end

	// sticky flags
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pending_q <= `TBU_RESET_BIT;
			missed_q  <= `TBU_RESET_BIT;
		end else begin
			pending_q <= pending_d;
			missed_q  <= missed_d;
		end
	end

	// registered outputs
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rdata_q <= '0;
			irq_q   <= `TBU_RESET_BIT;
		end else begin
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
		end
	end

	assign rdata_o = rdata_q;
	assign irq_o   = irq_q;
endmodule : tbu_periodic_tick_unit

/* rtl/tbu_pkg.sv */
package tbu_pkg;
	`include "tbu_cfg.svh"

	typedef logic [7:0] tbu_byte_t;
	typedef logic [3:0] tbu_addr_t;
	typedef logic [2:0] tbu_rate_t;
	typedef logic [1:0] tbu_osc_sel_t;

	// divider bit whose rising edge marks one period of the chosen rate
	function automatic int unsigned tbu_tap_index(input tbu_rate_t rate);
		unique case (rate)
			3'h0: tbu_tap_index = `TBU_TAP_R0;
			3'h1: tbu_tap_index = `TBU_TAP_R1;
			3'h2: tbu_tap_index = `TBU_TAP_R2;
			3'h3: tbu_tap_index = `TBU_TAP_R3;
			3'h4: tbu_tap_index = `TBU_TAP_R4;
			3'h5: tbu_tap_index = `TBU_TAP_R5;
			3'h6: tbu_tap_index = `TBU_TAP_R6;
			3'h7: tbu_tap_index = `TBU_TAP_R7;
		endcase
	endfunction : tbu_tap_index
endpackage : tbu_pkg

/* testbench/tbu_periodic_tick_unit_bench.sv */
`timescale 1ns/1ps
module tbu_periodic_tick_unit_bench;
	import tbu_pkg::*;
	logic      clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, osc = 0, keep = 1;
	logic      wait_mode_i = 0, stop_mode_i = 0, irq_o;
	tbu_addr_t addr_i = 4'h0;
	tbu_osc_sel_t sel = 2'h0;
	tbu_byte_t wdata_i = 8'h00, rdata_o, q;
	int        num_errors = 0, n_compared = 0, edges = 0, c1, c2;
	int        div [8] = '{262144, 131072, 65536, 32768, 64, 32, 16, 8};

	// bus clock, reference of twenty bus clocks, reference edge count
	always #12.5 clk_i = ~clk_i;
	always #250 osc = ~osc;
	always @(posedge osc) edges++;

	tbu_periodic_tick_unit tbu_periodic_tick_unit_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.osc_ref_clock_i(osc), .osc_sel_i(sel), .stop_internal_osc_keep_i(keep),
		.stop_rc_osc_keep_i(1'b0), .stop_crystal_osc_keep_i(1'b0), .wait_mode_i(wait_mode_i),
		.stop_mode_i(stop_mode_i), .irq_o(irq_o));

	task final_report;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report

	task chk(input tbu_byte_t got, input tbu_byte_t exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task wr(input tbu_addr_t a, input tbu_byte_t d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task rd(input tbu_addr_t a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 q = rdata_o;
	endtask : rd

	// poll status until pending, return reference edges seen
	task wait_flag(output int n);
		q = 8'h00;
		for (int i = 0; i < 2000 && q[0] !== 1'b1; i++) rd(4'h1);
		if (q[0] !== 1'b1) begin
			num_errors++;
			$display("BAD %0t flag wait ran out", $time);
			final_report();
		end
		n = edges;
	endtask : wait_flag

	initial begin
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(4'h0);
		chk(q, 8'h00);
		rd(4'hF);
		chk(q, 8'h00);
		for (int r = 0; r < 8; r++) begin
			@(negedge osc);
			wr(4'h0, 8'h08);
			wr(4'h0, {1'b0, 3'(r), 4'h2});
			edges = 0;
			rd(4'h0);
			chk(q, {1'b0, 3'(r), 4'h2});
			if (r > 3) begin
				wait_flag(c1);
				chk(8'(c1), 8'(div[r] / 2));
				wr(4'h0, {1'b0, 3'(r), 4'hA});
				wait_flag(c2);
				chk(8'(c2 - c1), 8'(div[r]));
			end
			$display("rate %0d done", r);
		end
		wr(4'h0, 8'h7E);
		wait_flag(c1);
		repeat (2) @(posedge clk_i);
		chk({7'h00, irq_o}, 8'h01);
		wr(4'h0, 8'h76);
		rd(4'h1);
		chk(q & 8'h01, 8'h01);
		rd(4'h0);
		chk(q & 8'h84, 8'h84);
		wr(4'h0, 8'h72);
		repeat (2) @(posedge clk_i);
		chk({7'h00, irq_o}, 8'h00);
		wr(4'h2, 8'h03);
		rd(4'h1);
		chk(q & 8'h01, 8'h00);
		$display("interrupt test done");
		@(posedge clk_i) wait_mode_i <= 1'b1;
		wr(4'h0, 8'h00);
		rd(4'h0);
		chk(q, 8'h00);
		repeat (200) @(posedge clk_i);
		wait_mode_i <= 1'b0;
		rd(4'h0);
		chk(q & 8'h82, 8'h82);
		wr(4'h0, 8'h7A);
		sel <= 2'h1;
		stop_mode_i <= 1'b1;
		repeat (400) @(posedge clk_i);
		stop_mode_i <= 1'b0;
		rd(4'h1);
		chk(q & 8'h01, 8'h00);
		sel <= 2'h0;
		stop_mode_i <= 1'b1;
		repeat (400) @(posedge clk_i);
		stop_mode_i <= 1'b0;
		rd(4'h1);
		chk(q & 8'h01, 8'h01);
		// unacknowledged periods raise the missed flag and its interrupt
		repeat (400) @(posedge clk_i);
		rd(4'h1);
		chk(q & 8'h03, 8'h03);
		wr(4'h3, 8'h02);
		repeat (2) @(posedge clk_i);
		chk({7'h00, irq_o}, 8'h01);
		wr(4'h2, 8'h03);
		rd(4'h1);
		chk(q & 8'h02, 8'h00);
		$display("low power test done");
		final_report();
	end
endmodule : tbu_periodic_tick_unit_bench

/* testbench/tbu_periodic_tick_unit_chk.sv */
`timescale 1ns/1ps
module tbu_tick_chk (
	input wire logic               clk_i,
	input wire logic               reset_n_i,
	input wire tbu_pkg::tbu_addr_t addr_i,
	input wire tbu_pkg::tbu_byte_t wdata_i,
	input wire logic               wr_i,
	input wire logic               rd_i,
	input wire tbu_pkg::tbu_byte_t rdata_o,
	input wire logic               wait_mode_i,
	input wire logic               stop_mode_i,
	input wire logic               irq_o
);
	import tbu_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// bus access allowed and acknowledge write decode
	wire cpu_ok = !wait_mode_i && !stop_mode_i;
	wire ack_wr = wr_i && cpu_ok && addr_i == 4'h0 && wdata_i[3];

	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside read slot");
	a_ack_reads_zero: assert property ($past(rd_i && addr_i == 4'h0) |-> !rdata_o[3])
		else $error("acknowledge bit read back set");
	a_clear_reads_zero: assert property ($past(rd_i && addr_i == 4'h2) |-> rdata_o == 8'h00)
		else $error("clear register read not zero");
	a_lowpower_blocked: assert property ($past(rd_i && !cpu_ok) |-> rdata_o == 8'h00)
		else $error("register reachable in low power mode");
	a_irq_reset_low: assert property ($rose(reset_n_i) |-> !irq_o [*2])
		else $error("interrupt after reset");
	a_irq_on_pending: assert property ($past(rd_i && addr_i == 4'h0) && rdata_o[7] && rdata_o[2]
		|-> ##[0:1] irq_o)
		else $error("no interrupt with flag and enable set");
	a_ack_drops_irq: assert property (ack_wr |-> ##[1:3] !irq_o)
		else $error("interrupt kept after acknowledge");
	a_irq_holds: assert property (irq_o && !wr_i && !$past(wr_i) |=> irq_o)
		else $error("interrupt dropped without a write");
endmodule : tbu_tick_chk

bind tbu_periodic_tick_unit tbu_tick_chk tbu_tick_chk_inst (.clk_i, .reset_n_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .wait_mode_i, .stop_mode_i, .irq_o);
